// *** testbench/pseu_pin_model.sv ***
// Purpose: Far-side devices on the five general pins.
// Assumes: The design wins the wire whenever it enables a pin.
// Notes: A pin nobody drives flips each cycle, so no stale level passes.
`timescale 1ns/1ps
`default_nettype none
module pseu_pin_model (
    input wire logic clk_in,
    input wire logic [5:1] ext_level_in,
    input wire logic [5:1] ext_en_in,
    input wire logic [5:1] drive_in,
    input wire logic [5:1] oe_in,
    output logic [5:1] wire_out
);
    logic [5:1] last_q = 5'h00;
    // ****************
    // Wire level
    // ****************
    // Remember the last level so a released pin can show its inverse.
    always @(posedge clk_in) begin
        last_q <= wire_out;
    end
    // Resolve each shared wire from the enables of both parties.
    always_comb begin
        for (int i = 1; i <= 5; i++) begin
            if (oe_in[i]) begin
                wire_out[i] = drive_in[i];
            end else if (ext_en_in[i]) begin
                wire_out[i] = ext_level_in[i];
            end else begin
                wire_out[i] = ~last_q[i];
            end
        end
    end
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// Purpose: Self-checking bench for the pin status and event unit.
// Assumes: Inputs change at the falling edge; read data is taken one cycle later.
// Notes: Random values come from a fixed xorshift seed.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_in, reset_in, rvalid_out, ir_data_in, irq_out, inv, irq_exp;
    pseu_pkg::pseu_req_t req_in;
    logic [15:0] rdata_out, rv, dirv, polv, wakev, exp_s;
    logic [5:1] pin_in, pin_out, pin_oe_out, ext_level, ext_en;
    logic [2:0] fault_in;
    logic [1:0] sh;
    logic [31:0] seed;
    int error_cnt, total_checks;
    logic [7:0] offs [8];
    logic [15:0] rsts [8];
    logic [15:0] impl [8];

    pseu_top dut (.clk_in(clk_in), .reset_in(reset_in), .req_in(req_in), .rdata_out(rdata_out),
        .rvalid_out(rvalid_out), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
        .fault_in(fault_in), .ir_data_in(ir_data_in), .irq_out(irq_out));
    pseu_pin_model far_side (.clk_in(clk_in), .ext_level_in(ext_level), .ext_en_in(ext_en),
        .drive_in(pin_out), .oe_in(pin_oe_out), .wire_out(pin_in));

    // ****************
    // Helpers
    // ****************
    // Clock of 10 ns period.
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Status is the activity after polarity; bypassed faults and a shared pin 2 read zero.
    function automatic logic [15:0] exp_stat(input logic [5:1] lv, input logic [2:0] ft,
        input logic [15:0] dir, input logic [15:0] pol, input logic [1:0] s);
        logic [15:0] act;
        act = ~({4'h0, ft, 3'h0, lv, 1'b0} ^ pol) & pseu_pkg::PSEU_SRC_MASK;
        act = act & (dir | pseu_pkg::PSEU_PIN_MASK);
        if (s != pseu_pkg::PSEU_SEL_GPIO) begin
            act[2] = 1'b0;
        end
        return act;
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Each access leaves a quiet cycle so no strobe is set twice in one step.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        req_in = {1'b1, 1'b0, a, d};
        @(negedge clk_in);
        req_in = '0;
        @(negedge clk_in);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
        req_in = {1'b0, 1'b1, a, 16'h0000};
        @(negedge clk_in);
        req_in = '0;
        chk({15'h0000, rvalid_out}, 16'h0001);
        chk(rdata_out, e);
        @(negedge clk_in);
    endtask
    task automatic report_and_stop();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // A hang counts as a mismatch.
    initial begin
        #1000000;
        error_cnt++;
        report_and_stop();
    end

    // ****************
    // Main sequence
    // ****************
    initial begin
        seed = 32'h6627;
        error_cnt = 0;
        total_checks = 0;
        reset_in = 1'b1;
        req_in = '0;
        ext_level = 5'h00;
        ext_en = 5'h1f;
        fault_in = 3'h0;
        ir_data_in = 1'b0;
        offs = '{pseu_pkg::PSEU_OFF_STAT, pseu_pkg::PSEU_OFF_DIR, pseu_pkg::PSEU_OFF_POL,
            pseu_pkg::PSEU_OFF_STK, pseu_pkg::PSEU_OFF_WAKE, pseu_pkg::PSEU_OFF_SHARE,
            pseu_pkg::PSEU_OFF_DRIVE, pseu_pkg::PSEU_OFF_MISC};
        rsts = '{pseu_pkg::PSEU_RST_STAT, pseu_pkg::PSEU_RST_DIR, pseu_pkg::PSEU_RST_POL,
            pseu_pkg::PSEU_RST_STK, pseu_pkg::PSEU_RST_WAKE, pseu_pkg::PSEU_RST_SHARE,
            pseu_pkg::PSEU_RST_DRIVE, pseu_pkg::PSEU_RST_MISC};
        impl = '{16'h0000, pseu_pkg::PSEU_SRC_MASK, pseu_pkg::PSEU_SRC_MASK, pseu_pkg::PSEU_SRC_MASK,
            pseu_pkg::PSEU_SRC_MASK, pseu_pkg::PSEU_SHARE_MASK, pseu_pkg::PSEU_PIN_MASK,
            pseu_pkg::PSEU_MISC_MASK};
        repeat (8) @(negedge clk_in);
        reset_in = 1'b0;
        // Status must be read at the very first edge, before live levels replace it.
        for (int i = 0; i < 8; i++) begin
            rdchk(offs[i], rsts[i]);
        end
        // All ones first, then random words; reserved bits never take a write.
        for (int k = 0; k < 3; k++) begin
            for (int i = 1; i < 8; i++) begin
                rv = (k == 0) ? 16'hffff : 16'(rnd());
                wr(offs[i], rv);
                rdchk(offs[i], (rv & impl[i]) | (rsts[i] & ~impl[i]));
            end
        end
        wr(8'h60, 16'hffff);
        rdchk(8'h60, 16'h0000);
        // Live status, polarity, bypass, pin 2 routing and the interrupt level.
        wr(offs[3], 16'h0000);
        for (int n = 0; n < 24; n++) begin
            rv = 16'(rnd());
            sh = rv[1:0];
            inv = rv[2];
            ir_data_in = rv[3];
            fault_in = rv[6:4];
            ext_level = rv[11:7];
            ext_en = (sh == pseu_pkg::PSEU_SEL_GPIO) ? 5'h1f : 5'h1d;
            dirv = (16'(rnd()) & pseu_pkg::PSEU_FAULT_MASK) | pseu_pkg::PSEU_PIN_MASK;
            polv = 16'(rnd()) & pseu_pkg::PSEU_SRC_MASK;
            wakev = 16'(rnd()) & pseu_pkg::PSEU_SRC_MASK;
            wr(offs[5], {12'h000, sh, 2'h0});
            wr(offs[1], dirv);
            wr(offs[2], polv);
            wr(offs[4], wakev);
            wr(offs[7], {15'h0000, inv});
            exp_s = exp_stat(ext_level, fault_in, dirv, polv, sh);
            irq_exp = (|(exp_s & wakev)) ^ inv;
            rdchk(offs[0], exp_s);
            chk({15'h0000, irq_out}, {15'h0000, irq_exp});
            case (sh)
                pseu_pkg::PSEU_SEL_IRQ: chk({14'h0, pin_oe_out[2], pin_out[2]}, {14'h0, 1'b1, irq_exp});
                pseu_pkg::PSEU_SEL_IR: chk({14'h0, pin_oe_out[2], pin_out[2]}, {14'h0, 1'b1, ir_data_in});
                default: chk({15'h0000, pin_oe_out[2]}, 16'h0000);
            endcase
        end
        // A short pulse stays latched until zero is written to its bit.
        ext_en = 5'h1f;
        ext_level = 5'h00;
        fault_in = 3'h0;
        wr(offs[5], 16'h0004);
        wr(offs[1], pseu_pkg::PSEU_RST_DIR);
        wr(offs[2], pseu_pkg::PSEU_RST_POL);
        wr(offs[7], 16'h0000);
        wr(offs[3], pseu_pkg::PSEU_SRC_MASK);
        wr(offs[4], 16'h0802);
        ext_level = 5'h01;
        fault_in = 3'h4;
        repeat (3) @(negedge clk_in);
        ext_level = 5'h00;
        fault_in = 3'h0;
        repeat (5) @(negedge clk_in);
        rdchk(offs[0], 16'h0802);
        chk({15'h0000, irq_out}, 16'h0001);
        wr(offs[0], 16'hffff);
        rdchk(offs[0], 16'h0802);
        wr(offs[0], 16'h0800);
        rdchk(offs[0], 16'h0800);
        wr(offs[0], 16'h0000);
        rdchk(offs[0], 16'h0000);
        chk({15'h0000, irq_out}, 16'h0000);
        // Output pins drive their control bits and still report the wire level.
        wr(offs[3], 16'h0000);
        ext_en = 5'h00;
        wr(offs[1], 16'h2e00);
        for (int n = 0; n < 4; n++) begin
            rv = (n == 0) ? pseu_pkg::PSEU_PIN_MASK : 16'(rnd()) & pseu_pkg::PSEU_PIN_MASK;
            wr(offs[6], rv);
            chk({6'h00, pin_oe_out, pin_out}, {6'h00, 5'h1f, rv[5:1]});
            repeat (3) @(negedge clk_in);
            rdchk(offs[0], exp_stat(rv[5:1], 3'h0, 16'h2e00, 16'h2e3e, 2'h1));
        end
        // A second reset in mid-run must bring every register back to its reset value.
        reset_in = 1'b1;
        repeat (2) @(negedge clk_in);
        reset_in = 1'b0;
        for (int i = 0; i < 8; i++) begin
            rdchk(offs[i], rsts[i]);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire

// *** verilog/pseu_pkg.sv ***
// Purpose: Shared constants and types of the pin status and event unit.
// Assumes: Registers are 16 bits wide and sit at their byte offsets.
// Notes: Masks mark which bits of each word are implemented.
`default_nettype none
package pseu_pkg;
    // ****************************************
    // Register offsets.
    // ****************************************
    localparam logic [7:0] PSEU_OFF_DIR = 8'h4c;
    localparam logic [7:0] PSEU_OFF_POL = 8'h4e;
    localparam logic [7:0] PSEU_OFF_STK = 8'h50;
    localparam logic [7:0] PSEU_OFF_WAKE = 8'h52;
    localparam logic [7:0] PSEU_OFF_STAT = 8'h54;
    localparam logic [7:0] PSEU_OFF_SHARE = 8'h56;
    localparam logic [7:0] PSEU_OFF_DRIVE = 8'h5c;
    localparam logic [7:0] PSEU_OFF_MISC = 8'h5e;

    // ****************************************
    // Reset values and implemented bits.
    // ****************************************
    localparam logic [15:0] PSEU_RST_DIR = 16'h2e3e;
    localparam logic [15:0] PSEU_RST_POL = 16'h2e3e;
    localparam logic [15:0] PSEU_RST_STK = 16'h0000;
    localparam logic [15:0] PSEU_RST_WAKE = 16'h0000;
    localparam logic [15:0] PSEU_RST_STAT = 16'h003a;
    localparam logic [15:0] PSEU_RST_SHARE = 16'h0000;
    localparam logic [15:0] PSEU_RST_DRIVE = 16'h0000;
    localparam logic [15:0] PSEU_RST_MISC = 16'h0000;
    localparam logic [15:0] PSEU_SRC_MASK = 16'h0e3e;
    localparam logic [15:0] PSEU_FAULT_MASK = 16'h0e00;
    localparam logic [15:0] PSEU_PIN_MASK = 16'h003e;
    localparam logic [15:0] PSEU_SHARE_MASK = 16'h000c;
    localparam logic [15:0] PSEU_MISC_MASK = 16'h0001;

    // ****************************************
    // Field positions.
    // ****************************************
    localparam int PSEU_PIN_LO = 1;
    localparam int PSEU_PIN_HI = 5;
    localparam int PSEU_FAULT_LO = 9;
    localparam int PSEU_FAULT_HI = 11;
    localparam int PSEU_SECOND_PIN = 2;
    localparam int PSEU_SEL_LO = 2;
    localparam int PSEU_SEL_HI = 3;
    localparam int PSEU_IRQ_INV_BIT = 0;

    // ****************************************
    // Function codes of the second pin.
    // ****************************************
    localparam logic [1:0] PSEU_SEL_IRQ = 2'h0;
    localparam logic [1:0] PSEU_SEL_GPIO = 2'h1;
    localparam logic [1:0] PSEU_SEL_IR = 2'h2;

    // Register access request from the control port.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] data;
    } pseu_req_t;
endpackage
`default_nettype wire

// *** verilog/pseu_sync.sv ***
// Purpose: Two-stage synchroniser for a vector of level inputs.
// Assumes: Each bit is an independent level; no word coherence is given.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module pseu_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_one;
    logic [WIDTH-1:0] next_stage_one;
    logic [WIDTH-1:0] next_sync;

    if (WIDTH < 1) begin : g_check
        $error("pseu_sync needs a width of at least one.");
    end

    // The next values simply shift the input through both stages.
    always_comb begin
        next_stage_one = async_in;
        next_sync = stage_one;
    end

    // Both stages clear on reset so status starts from a known level.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            stage_one <= '0;
            sync_out <= '0;
        end else begin
            stage_one <= next_stage_one;
            sync_out <= next_sync;
        end
    end

    // ****************************************
    // Assertions.
    // ****************************************
    // Once reset has been gone for two edges the output is the input of two edges back.
    property p_sync;
        @(posedge clk_in) disable iff (reset_in)
        (!$past(reset_in) && !$past(reset_in, 2)) |-> (sync_out == $past(async_in, 2));
    endproperty
    a_sync: assert property (p_sync) else $error("Synchroniser latency is not two cycles."); // [R14]
endmodule
`default_nettype wire

// *** verilog/pseu_top.sv ***
// Purpose: Five general pins and three fault sources with status, sticky and wake-up logic.
// Assumes: Register requests arrive as one-cycle strobes on the control port.
// Notes: Status of a sticky source holds until software writes zero to it, clears its sticky enable, bypasses it or moves pin 2 to another function.
// Notes on behaviour
// R1: Direction bits 5..1 make a pin output at 0, input at 1; inputs after reset.
// R2: Fault configure bits 11..9 bypass at 0, normal at 1; normal after reset.
// R3: Polarity 0 means low active, 1 high active; every polarity resets to 1.
// R4: Sticky enable 1 latches an active indication; 0 lets status follow live level.
// R5: Wake-up enable 1 lets a source cause wake-up; resets to 0.
// R6: Status read returns pins at bits 5..1 and faults at bits 11..9.
// R7: Writing zero to a status bit clears its latch; written values are not stored.
// R8: Status reads 0x003a straight after reset.
// R9: Second pin function: 00 interrupt, 01 pin, 10 infrared data, 11 reserved.
// R10: Bits 8..6 and bit 0 of the source registers read as zero.
// R11: Each output pin drives the level of its drive control bit.
// R12: An inversion bit flips the interrupt output level when set.
// R13: Interrupt asserts when any used source shows active status with wake-up enabled.
// R14: Every source is synchronised to the clock before any further use.
`timescale 1ns/1ps
`default_nettype none
module pseu_top (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire pseu_pkg::pseu_req_t req_in,
    output logic [15:0] rdata_out,
    output logic rvalid_out,
    input wire logic [5:1] pin_in,
    output logic [5:1] pin_out,
    output logic [5:1] pin_oe_out,
    input wire logic [2:0] fault_in,
    input wire logic ir_data_in,
    output logic irq_out
);
    // ****************************************
    // Registers and next values.
    // ****************************************
    logic [15:0] dir_cfg;
    logic [15:0] pol;
    logic [15:0] stk;
    logic [15:0] wake;
    logic [15:0] status;
    logic [15:0] share;
    logic [15:0] drive;
    logic [15:0] misc;
    logic [15:0] rdata;
    logic rvalid;
    logic [15:0] next_dir_cfg;
    logic [15:0] next_pol;
    logic [15:0] next_stk;
    logic [15:0] next_wake;
    logic [15:0] next_status;
    logic [15:0] next_share;
    logic [15:0] next_drive;
    logic [15:0] next_misc;
    logic [15:0] next_rdata;
    logic next_rvalid;
    logic [5:1] pin_sync;
    logic [2:0] fault_sync;
    logic [15:0] src;
    logic [15:0] use_v;
    logic [15:0] act_v;
    logic [15:0] clr_v;
    logic [1:0] sel;
    logic irq_raw;
    logic irq_level;

    // ****************************************
    // Input synchronisation.
    // ****************************************
    // Pins and analog detectors change at any time, so both pass two flops first.
    pseu_sync #(.WIDTH(8)) u_sync (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .async_in({fault_in, pin_in}), // [R14]
        .sync_out({fault_sync, pin_sync})
    );

    // Sources laid out at their status bit positions; fault 0 is bias two at bit 9.
    assign src = {4'h0, fault_sync, 3'h0, pin_sync, 1'b0};
    assign sel = share[pseu_pkg::PSEU_SEL_HI:pseu_pkg::PSEU_SEL_LO];

    // ****************************************
    // Status evaluation.
    // ****************************************
    // A bypassed fault, or the second pin while it serves another function, never shows active.
    always_comb begin
        use_v = pseu_pkg::PSEU_SRC_MASK & (dir_cfg | ~pseu_pkg::PSEU_FAULT_MASK); // [R2]
        if (sel != pseu_pkg::PSEU_SEL_GPIO) begin
            use_v[pseu_pkg::PSEU_SECOND_PIN] = 1'b0; // [R9]
        end
        act_v = use_v & ~(src ^ pol); // [R3]
        clr_v = '0;
        if (req_in.wr && req_in.addr == pseu_pkg::PSEU_OFF_STAT) begin
            clr_v = ~req_in.data; // [R7]
        end
    end

    // Interrupt is the OR of enabled, active status bits, optionally inverted.
    always_comb begin
        irq_raw = |(status & wake & pseu_pkg::PSEU_SRC_MASK); // [R5] [R13]
        irq_level = irq_raw ^ misc[pseu_pkg::PSEU_IRQ_INV_BIT]; // [R12]
    end

    // ****************************************
    // Register next values.
    // ****************************************
    // Write decode; a new event wins over a clear in the same cycle.
    always_comb begin
        next_dir_cfg = dir_cfg;
        next_pol = pol;
        next_stk = stk;
        next_wake = wake;
        next_share = share;
        next_drive = drive;
        next_misc = misc;
        // Latched bits survive only when sticky and not cleared; live bits are re-evaluated.
        next_status = act_v | (stk & status & ~clr_v & use_v); // [R4] [R7]
        if (req_in.wr) begin
            if (req_in.addr == pseu_pkg::PSEU_OFF_DIR) begin
                next_dir_cfg = req_in.data & pseu_pkg::PSEU_SRC_MASK; // [R1] [R2]
            end else if (req_in.addr == pseu_pkg::PSEU_OFF_POL) begin
                next_pol = req_in.data & pseu_pkg::PSEU_SRC_MASK; // [R3]
            end else if (req_in.addr == pseu_pkg::PSEU_OFF_STK) begin
                next_stk = req_in.data & pseu_pkg::PSEU_SRC_MASK; // [R4]
            end else if (req_in.addr == pseu_pkg::PSEU_OFF_WAKE) begin
                next_wake = req_in.data & pseu_pkg::PSEU_SRC_MASK; // [R5]
            end else if (req_in.addr == pseu_pkg::PSEU_OFF_SHARE) begin
                next_share = req_in.data & pseu_pkg::PSEU_SHARE_MASK; // [R9]
            end else if (req_in.addr == pseu_pkg::PSEU_OFF_DRIVE) begin
                next_drive = req_in.data & pseu_pkg::PSEU_PIN_MASK; // [R11]
            end else if (req_in.addr == pseu_pkg::PSEU_OFF_MISC) begin
                next_misc = req_in.data & pseu_pkg::PSEU_MISC_MASK; // [R12]
            end
        end
    end

    // Read decode; reserved upper bits of direction and polarity read their fixed reset value.
    always_comb begin
        next_rvalid = req_in.rd;
        next_rdata = rdata;
        if (req_in.rd) begin
            if (req_in.addr == pseu_pkg::PSEU_OFF_DIR) begin
                next_rdata = dir_cfg | (pseu_pkg::PSEU_RST_DIR & ~pseu_pkg::PSEU_SRC_MASK); // [R10]
            end else if (req_in.addr == pseu_pkg::PSEU_OFF_POL) begin
                next_rdata = pol | (pseu_pkg::PSEU_RST_POL & ~pseu_pkg::PSEU_SRC_MASK); // [R10]
            end else if (req_in.addr == pseu_pkg::PSEU_OFF_STK) begin
                next_rdata = stk;
            end else if (req_in.addr == pseu_pkg::PSEU_OFF_WAKE) begin
                next_rdata = wake;
            end else if (req_in.addr == pseu_pkg::PSEU_OFF_STAT) begin
                next_rdata = status; // [R6]
            end else if (req_in.addr == pseu_pkg::PSEU_OFF_SHARE) begin
                next_rdata = share;
            end else if (req_in.addr == pseu_pkg::PSEU_OFF_DRIVE) begin
                next_rdata = drive;
            end else if (req_in.addr == pseu_pkg::PSEU_OFF_MISC) begin
                next_rdata = misc;
            end else begin
                next_rdata = 16'h0000;
            end
        end
    end

    // All control state returns to its documented value on reset.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            dir_cfg <= pseu_pkg::PSEU_RST_DIR & pseu_pkg::PSEU_SRC_MASK; // [R1] [R2]
            pol <= pseu_pkg::PSEU_RST_POL & pseu_pkg::PSEU_SRC_MASK; // [R3]
            stk <= pseu_pkg::PSEU_RST_STK;
            wake <= pseu_pkg::PSEU_RST_WAKE;
            status <= pseu_pkg::PSEU_RST_STAT; // [R8]
            share <= pseu_pkg::PSEU_RST_SHARE;
            drive <= pseu_pkg::PSEU_RST_DRIVE;
            misc <= pseu_pkg::PSEU_RST_MISC;
            rdata <= 16'h0000;
            rvalid <= 1'b0;
        end else begin
            dir_cfg <= next_dir_cfg;
            pol <= next_pol;
            stk <= next_stk;
            wake <= next_wake;
            status <= next_status;
            share <= next_share;
            drive <= next_drive;
            misc <= next_misc;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    // ****************************************
    // Pin drivers.
    // ****************************************
    // The second pin carries the interrupt or infrared data regardless of its direction bit.
    always_comb begin
        pin_out = drive[pseu_pkg::PSEU_PIN_HI:pseu_pkg::PSEU_PIN_LO]; // [R11]
        pin_oe_out = ~dir_cfg[pseu_pkg::PSEU_PIN_HI:pseu_pkg::PSEU_PIN_LO]; // [R1]
        if (sel == pseu_pkg::PSEU_SEL_IRQ) begin
            pin_out[pseu_pkg::PSEU_SECOND_PIN] = irq_level; // [R9]
            pin_oe_out[pseu_pkg::PSEU_SECOND_PIN] = 1'b1;
        end else if (sel == pseu_pkg::PSEU_SEL_IR) begin
            pin_out[pseu_pkg::PSEU_SECOND_PIN] = ir_data_in; // [R9]
            pin_oe_out[pseu_pkg::PSEU_SECOND_PIN] = 1'b1;
        end else if (sel != pseu_pkg::PSEU_SEL_GPIO) begin
            pin_oe_out[pseu_pkg::PSEU_SECOND_PIN] = 1'b0;
        end
    end

    assign irq_out = irq_level;
    assign rdata_out = rdata;
    assign rvalid_out = rvalid;

    // ****************************************
    // Assertions.
    // ****************************************
    property p_dir;
        @(posedge clk_in) disable iff (reset_in)
        (req_in.wr && req_in.addr == pseu_pkg::PSEU_OFF_DIR) |=> (pin_oe_out[5:3] == ~$past(req_in.data[5:3]));
    endproperty
    a_dir: assert property (p_dir) else $error("Direction write did not steer output enables."); // [R1]

    property p_bypass;
        @(posedge clk_in) disable iff (reset_in)
        (!dir_cfg[9] && !(req_in.wr && req_in.addr == pseu_pkg::PSEU_OFF_DIR)) |=> !status[9];
    endproperty
    a_bypass: assert property (p_bypass) else $error("Bypassed fault shows status."); // [R2]

    property p_polarity;
        @(posedge clk_in) disable iff (reset_in)
        (!stk[10] && dir_cfg[10]) |=> (status[10] == ($past(src[10]) ~^ $past(pol[10])));
    endproperty
    a_polarity: assert property (p_polarity) else $error("Live status ignores polarity."); // [R3]

    property p_sticky;
        @(posedge clk_in) disable iff (reset_in)
        (stk[1] && status[1] && !clr_v[1]) |=> status[1];
    endproperty
    a_sticky: assert property (p_sticky) else $error("Sticky status was lost."); // [R4]

    property p_clear;
        @(posedge clk_in) disable iff (reset_in)
        (clr_v[11] && !act_v[11]) |=> !status[11];
    endproperty
    a_clear: assert property (p_clear) else $error("Writing zero did not clear status."); // [R7]

    property p_reset_stat;
        @(posedge clk_in) $fell(reset_in) |-> (status == 16'h003a);
    endproperty
    a_reset_stat: assert property (p_reset_stat) else $error("Status wrong after reset."); // [R8]

    property p_irq_pin;
        @(posedge clk_in) disable iff (reset_in)
        (sel == 2'h0) |-> (pin_oe_out[2] && pin_out[2] == irq_out);
    endproperty
    a_irq_pin: assert property (p_irq_pin) else $error("Second pin not carrying interrupt."); // [R9]

    // Bit 0 of the misc word is the live interrupt invert control, so only that read may show it set.
    property p_reserved;
        @(posedge clk_in) disable iff (reset_in)
        req_in.rd |=> (rdata_out[8:6] == 3'h0 && rvalid_out &&
            (!rdata_out[0] || $past(req_in.addr) == pseu_pkg::PSEU_OFF_MISC));
    endproperty
    a_reserved: assert property (p_reserved) else $error("Reserved bits read non-zero."); // [R10]

    property p_drive;
        @(posedge clk_in) disable iff (reset_in)
        (req_in.wr && req_in.addr == pseu_pkg::PSEU_OFF_DRIVE) |=> (pin_out[5] == $past(req_in.data[5]));
    endproperty
    a_drive: assert property (p_drive) else $error("Drive level not applied."); // [R11]

    property p_irq;
        @(posedge clk_in) disable iff (reset_in)
        (wake[9] && status[9]) |-> (irq_out != misc[0]);
    endproperty
    a_irq: assert property (p_irq) else $error("Enabled active source gave no interrupt."); // [R12] [R13]
endmodule
`default_nettype wire
